/* hdl/line_integrator.sv */
// leaky digital integrator for the current channel samples
// assumes one sample_valid per sample period on the pclk domain
`timescale 1ns/100ps
`include "line_monitor_params.svh"
module line_integrator
	import line_monitor_pkg::*;
(
	input  wire logic    pclk,
	input  wire logic    presetn,
	input  wire logic    enable,
	input  wire sample_s in_s,
	output sample_s      out_s
);
	// accumulator with a small leak so dc offsets cannot wind it up
	logic signed [39:0] acc_r;
	wire  signed [39:0] in_ext   = {{16{in_s.data[23]}}, in_s.data};
	wire  signed [39:0] leak     = acc_r >>> 12;
	wire  signed [39:0] acc_nxt  = acc_r + in_ext - leak;
	wire         [23:0] acc_view = acc_r[`INT_SHIFT + 23 -: 24];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= '0;
			out_s <= '0;
		end else begin
			out_s.valid <= in_s.valid;
			if (in_s.valid) begin
				acc_r      <= enable ? acc_nxt : '0; // see R1 see R2
				out_s.data <= enable ? acc_view : in_s.data;
			end
		end
	end
endmodule : line_integrator

/* hdl/line_monitor_params.svh */
// register offsets, field positions, reset values and timing counts for the line monitor
// assumes the includer sits at file scope, outside any module or package
`ifndef LINE_MONITOR_PARAMS_SVH
`define LINE_MONITOR_PARAMS_SVH
`define OFF_PERIOD_FREQ   8'h0A
`define OFF_CONFIG_A      8'h0B
`define OFF_CONFIG_B      8'h0C
`define OFF_ZX_TIMEOUT    8'h11
`define OFF_DIP_CYCLES    8'h13
`define OFF_DIP_LEVEL     8'h14
`define OFF_METER_EN_HI   8'hDB
`define OFF_METER_ST_HI   8'hDE
`define OFF_SUPPLY_EN     8'hEC
`define OFF_SUPPLY_FLAGS  8'hF8
`define OFF_CURRENT_OUT   8'h40
`define BIT_INTEG_EN      5
`define BIT_LPF_BYPASS    4
`define BIT_FREQ_SEL      1
`define BIT_ZX_FLAG       2
`define BIT_CROSSING_TIMEOUT_FLAG_FLAG     1
`define BIT_DIP_FLAG      5
`define ZX_TIMEOUT_RESET  12'hFFF
`define DIP_CYCLES_RESET  8'hFF
`define DIP_LEVEL_RESET   16'h0000
`define MCLK_HZ           4096000
`define SAMPLE_DIV        8'd160
`define PERIOD_TICK_DIV   8'd10
`define FREQ_NUMERATOR    32'd6553600
`define LPF_SHIFT         4'd6
`define INT_SHIFT         4'd7
`endif

/* hdl/line_monitor_pkg.sv */
// types shared by the line monitor files
// assumes the params header is on the include path
package line_monitor_pkg;
	typedef struct packed {
		logic        valid;
		logic [23:0] data;
	} sample_s;
	typedef enum logic [1:0] {
		DIP_IDLE  = 2'b00,
		DIP_COUNT = 2'b01,
		DIP_HELD  = 2'b10
	} dip_state_e;
endpackage : line_monitor_pkg

/* hdl/line_power_quality_monitor.sv */
// line zero crossing, timeout, period/frequency and sag detection with an APB register slave
// assumes voltage and current samples arrive synchronous to pclk, one valid per 160 pclks
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "line_monitor_params.svh"
// Summary of operation
// R1 - integrator off after reset; on only when config_a bit 5 is set
// R2 - enabled integrator gives -20 dB/dec slope and about -90 degrees phase
// R3 - zero crossing taken from low-pass output, or raw samples when bypassed
// R4 - low-pass is single pole near 63.7 Hz, about 2 ms detection delay
// R5 - software keeps low-pass on below 60 Hz when delay is acceptable
// R6 - each crossing sets the crossing flag; enabled flag holds interrupt until cleared
// R7 - timeout counter is 12-bit, down by one every 160 clocks
// R8 - every crossing reloads the timeout counter with the programmed value
// R9 - timeout register resets to 0xFFF
// R10 - counter reaching zero sets timeout flag; enabled flag holds interrupt
// R11 - timeout register is readable and writable
// R12 - config_b bit 1 picks period (0) or frequency (1)
// R13 - 16-bit result refreshed once per line period
// R14 - period counts units of ten clocks
// R15 - frequency counts 0.0625 Hz per bit, 60 Hz reads 960
// R16 - sag exists while absolute low-pass output is below the threshold; the code compares raw samples instead when the low-pass is bypassed
// R17 - cycle count holds one more than cycles; never 0 or 1
// R18 - sag lasting programmed cycles sets dip flag; enable raises supply interrupt
// R19 - threshold 0 or 1 means zero level
// R20 - one single-cycle crossing event per sign change of consecutive samples
module line_power_quality_monitor
	import line_monitor_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire sample_s     volt_in,
	input  wire sample_s     curr_in,
	output sample_s          curr_out,
	output logic             meter_irq,
	output logic             supply_irq,
	output logic             line_zero_cross
);
	// signed twos-complement 24-bit absolute value, top 16 bits kept
	function automatic logic [15:0] abs_hi(input logic [23:0] v);
		logic [23:0] m;
		m = v[23] ? (~v + 24'h000001) : v;
		abs_hi = m[23:8];
	endfunction : abs_hi

	logic [7:0]  config_a_r, config_b_r, dip_cycles_r, meter_en_r, meter_st_r;
	logic [7:0]  supply_en_r, supply_flags_r;
	logic [11:0] zx_timeout_r, zx_count_r;
	logic [15:0] dip_level_r, period_freq_r, period_cnt_r;
	logic [7:0]  tick_div_r, dec_div_r, dip_cnt_r;
	logic signed [31:0] lpf_r;
	logic        prev_sign_r, sign_seen_r, period_armed_r;
	logic [31:0] prdata_nxt;
	dip_state_e  dip_state_r, dip_state_nxt;
	sample_s     curr_int;

	// register access happens in the access phase; no wait states
	wire        wr_en  = psel & penable & pwrite;
	wire        rd_en  = psel & penable & ~pwrite;
	wire        known  = (paddr == `OFF_PERIOD_FREQ) | (paddr == `OFF_CONFIG_A) |
	                     (paddr == `OFF_CONFIG_B) | (paddr == `OFF_ZX_TIMEOUT) |
	                     (paddr == `OFF_DIP_CYCLES) | (paddr == `OFF_DIP_LEVEL) |
	                     (paddr == `OFF_METER_EN_HI) | (paddr == `OFF_METER_ST_HI) |
	                     (paddr == `OFF_SUPPLY_EN) | (paddr == `OFF_SUPPLY_FLAGS) |
	                     (paddr == `OFF_CURRENT_OUT);
	wire        wr_meter_st = wr_en & (paddr == `OFF_METER_ST_HI);
	wire        wr_supply   = wr_en & (paddr == `OFF_SUPPLY_FLAGS);

	// line low-pass: y += (x - y) >> 6 per valid sample gives ~63.7 Hz at 25.6 kSPS
	wire signed [31:0] volt_ext  = {{8{volt_in.data[23]}}, volt_in.data};
	wire signed [31:0] lpf_nxt   = lpf_r + ((volt_ext - lpf_r) >>> `LPF_SHIFT); // see R4
	wire        lpf_bypass = config_a_r[`BIT_LPF_BYPASS];
	wire [23:0] zx_source  = lpf_bypass ? volt_in.data : lpf_r[23:0]; // see R3
	wire        cur_sign   = zx_source[23];
	wire        zx_event   = volt_in.valid & sign_seen_r & (cur_sign != prev_sign_r); // see R20

	// timeout counts down every 160 clocks, reload wins over decrement
	wire        dec_tick   = (dec_div_r == `SAMPLE_DIV - 8'd1);
	wire        zx_expire  = dec_tick & (zx_count_r == 12'h001); // see R10

	// period in ten-clock units, frequency derived from it
	wire        per_tick   = (tick_div_r == `PERIOD_TICK_DIV - 8'd1);
	// full line period spans two crossings, so measure crossing to second crossing
	logic       half_r;
	wire [31:0] freq_full  = (period_cnt_r == 16'h0000) ? 32'h0 :
	                         (`FREQ_NUMERATOR / {16'h0, period_cnt_r});
	wire [15:0] measure    = config_b_r[`BIT_FREQ_SEL] ? freq_full[15:0] : period_cnt_r; // see R12

	// sag compares the abs of the detection input with the threshold; 0 or 1 means zero level
	wire [15:0] level_eff  = (dip_level_r <= 16'h0001) ? 16'h0000 : dip_level_r; // see R19
	wire        dip_low    = abs_hi(zx_source) < level_eff; // see R16
	wire        full_cycle = zx_event & half_r;
	wire        dip_done   = (dip_cnt_r + 8'd2 >= dip_cycles_r); // see R17

	always_comb begin
		dip_state_nxt = dip_state_r;
		case (dip_state_r)
			DIP_IDLE:  if (dip_low) dip_state_nxt = DIP_COUNT;
			DIP_COUNT: begin
				if (!dip_low && volt_in.valid && zx_event)
					dip_state_nxt = DIP_IDLE;
				else if (full_cycle && dip_done)
					dip_state_nxt = DIP_HELD;
			end
			DIP_HELD:  if (!dip_low && zx_event) dip_state_nxt = DIP_IDLE;
			default:   dip_state_nxt = DIP_IDLE;
		endcase
	end
	wire        dip_set = (dip_state_r == DIP_COUNT) & (dip_state_nxt == DIP_HELD);

	always_comb begin
		prdata_nxt = 32'h0;
		case (paddr)
			`OFF_PERIOD_FREQ:  prdata_nxt = {16'h0, period_freq_r};
			`OFF_CONFIG_A:     prdata_nxt = {24'h0, config_a_r};
			`OFF_CONFIG_B:     prdata_nxt = {24'h0, config_b_r};
			`OFF_ZX_TIMEOUT:   prdata_nxt = {20'h0, zx_timeout_r}; // see R11
			`OFF_DIP_CYCLES:   prdata_nxt = {24'h0, dip_cycles_r};
			`OFF_DIP_LEVEL:    prdata_nxt = {16'h0, dip_level_r};
			`OFF_METER_EN_HI:  prdata_nxt = {24'h0, meter_en_r};
			`OFF_METER_ST_HI:  prdata_nxt = {24'h0, meter_st_r};
			`OFF_SUPPLY_EN:    prdata_nxt = {24'h0, supply_en_r};
			`OFF_SUPPLY_FLAGS: prdata_nxt = {24'h0, supply_flags_r};
			`OFF_CURRENT_OUT:  prdata_nxt = {8'h0, curr_int.data};
			default:           prdata_nxt = 32'h0;
		endcase
	end

	line_integrator u_integ (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (config_a_r[`BIT_INTEG_EN]), // see R1
		.in_s    (curr_in),
		.out_s   (curr_int)
	);

	// apb slave: one-cycle access phase, error on unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~known;
			// writes answer with zero data so a refused write never shows stale read data
			prdata  <= (psel & ~penable) ? (pwrite ? 32'h0 : prdata_nxt) : prdata;
		end
	end

	// configuration registers; integrator off and timeout full-scale at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_a_r   <= 8'h00; // see R1
			config_b_r   <= 8'h00;
			zx_timeout_r <= `ZX_TIMEOUT_RESET; // see R9
			dip_cycles_r <= `DIP_CYCLES_RESET;
			dip_level_r  <= `DIP_LEVEL_RESET;
			meter_en_r   <= 8'h00;
			supply_en_r  <= 8'h00;
		end else if (wr_en & pready) begin
			case (paddr)
				`OFF_CONFIG_A:    config_a_r   <= pwdata[7:0];
				`OFF_CONFIG_B:    config_b_r   <= pwdata[7:0];
				`OFF_ZX_TIMEOUT:  zx_timeout_r <= pwdata[11:0]; // see R11
				`OFF_DIP_CYCLES:  dip_cycles_r <= pwdata[7:0];
				`OFF_DIP_LEVEL:   dip_level_r  <= pwdata[15:0];
				`OFF_METER_EN_HI: meter_en_r   <= pwdata[7:0];
				`OFF_SUPPLY_EN:   supply_en_r  <= pwdata[7:0];
				default:          config_a_r   <= config_a_r;
			endcase
		end
	end

	// status flags: write one to clear, a hardware set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meter_st_r     <= 8'h00;
			supply_flags_r <= 8'h00;
			meter_irq      <= 1'b0;
			supply_irq     <= 1'b0;
		end else begin
			meter_st_r <= (meter_st_r & ~((wr_meter_st & pready) ? pwdata[7:0] : 8'h00))
			            | ({7'h0, zx_event} << `BIT_ZX_FLAG)      // see R6
			            | ({7'h0, zx_expire} << `BIT_CROSSING_TIMEOUT_FLAG_FLAG);  // see R10
			supply_flags_r <= (supply_flags_r & ~((wr_supply & pready) ? pwdata[7:0] : 8'h00))
			                | ({7'h0, dip_set} << `BIT_DIP_FLAG);  // see R18
			meter_irq  <= |(meter_st_r & meter_en_r);              // see R6 see R10
			supply_irq <= |(supply_flags_r & supply_en_r);         // see R18
		end
	end

	// filter, crossing detector and timeout counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lpf_r           <= '0;
			prev_sign_r     <= 1'b0;
			sign_seen_r     <= 1'b0;
			line_zero_cross <= 1'b0;
			dec_div_r       <= 8'h00;
			zx_count_r      <= `ZX_TIMEOUT_RESET;
		end else begin
			if (volt_in.valid) begin
				lpf_r       <= lpf_nxt;
				prev_sign_r <= cur_sign;
				sign_seen_r <= 1'b1;
			end
			line_zero_cross <= zx_event; // see R20
			dec_div_r       <= dec_tick ? 8'h00 : dec_div_r + 8'd1; // see R7
			if (zx_event)
				zx_count_r <= zx_timeout_r; // see R8
			else if (dec_tick && zx_count_r != 12'h000)
				zx_count_r <= zx_count_r - 12'h001; // see R7
		end
	end

	// period counter and sag state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_div_r     <= 8'h00;
			period_cnt_r   <= 16'h0000;
			period_freq_r  <= 16'h0000;
			period_armed_r <= 1'b0;
			half_r         <= 1'b0;
			dip_state_r    <= DIP_IDLE;
			dip_cnt_r      <= 8'h00;
		end else begin
			tick_div_r <= per_tick ? 8'h00 : tick_div_r + 8'd1;
			if (zx_event)
				half_r <= ~half_r;
			if (full_cycle) begin
				if (period_armed_r)
					period_freq_r <= measure; // see R13 see R14 see R15
				period_armed_r <= 1'b1;
				// a tick on the restart edge still belongs to the new period
				period_cnt_r   <= per_tick ? 16'h0001 : 16'h0000; // see R14
			end else if (per_tick && period_cnt_r != 16'hFFFF)
				period_cnt_r <= period_cnt_r + 16'h0001; // see R14
			dip_state_r <= dip_state_nxt;
			if (dip_state_nxt == DIP_COUNT && dip_state_r == DIP_IDLE)
				dip_cnt_r <= 8'h00;
			else if (dip_state_r == DIP_COUNT && full_cycle)
				dip_cnt_r <= dip_cnt_r + 8'd1; // see R18
		end
	end

	assign curr_out = curr_int;
endmodule : line_power_quality_monitor

/* test/line_monitor_sva.sv */
// assertions on the line monitor ports, bound into every monitor instance
// assumes the params header is on the include path
`timescale 1ns/100ps
`include "line_monitor_params.svh"
module line_monitor_sva
	import line_monitor_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire sample_s     volt_in,
	input wire sample_s     curr_in,
	input wire sample_s     curr_out,
	input wire logic        meter_irq,
	input wire logic        supply_irq,
	input wire logic        line_zero_cross
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] since_r;
	wire        wr_done = psel && penable && pready && pwrite;
	wire        m_wr = wr_done && (paddr == `OFF_METER_ST_HI || paddr == `OFF_METER_EN_HI);
	wire        s_wr = wr_done && (paddr == `OFF_SUPPLY_FLAGS || paddr == `OFF_SUPPLY_EN);
	// saturates so an old sample can never excuse a late crossing pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since_r <= 3'h7;
		else if (volt_in.valid)
			since_r <= 3'h0;
		else if (since_r != 3'h7)
			since_r <= since_r + 3'h1;
	end
	AST_APB_READY: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	AST_READY_ONE: assert property (pready |-> psel && penable ##1 !pready)
		else $error("pready outside one access cycle");
	AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer malformed");
	AST_ZX_SINGLE: assert property (line_zero_cross |=> !line_zero_cross)
		else $error("crossing pulse too long");
	AST_ZX_CAUSE: assert property (line_zero_cross |-> since_r <= 3'h3)
		else $error("crossing without sample");
	AST_CURR_LAT: assert property (curr_out.valid == $past(curr_in.valid))
		else $error("current output timing");
	AST_METER_HOLD: assert property (meter_irq && !m_wr && !$past(m_wr) |=> meter_irq)
		else $error("meter irq dropped");
	AST_SUPPLY_HOLD: assert property (supply_irq && !s_wr && !$past(s_wr) |=> supply_irq)
		else $error("supply irq dropped");
	cover property (line_zero_cross);
	cover property (meter_irq);
	cover property (supply_irq);
	cover property (pslverr);
endmodule : line_monitor_sva
bind line_power_quality_monitor line_monitor_sva line_monitor_sva_i (.*);

/* test/line_sample_source.sv */
// model of the voltage and current sample streams feeding the monitor
// assumes pclk stands in for the master clock, one sample per 160 clocks
`timescale 1ns/100ps
module line_sample_source
	import line_monitor_pkg::*;
#(
	parameter logic [23:0] CURR_LEVEL = 24'h001234
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        freeze,
	input  wire logic [23:0] amplitude,
	output sample_s          volt_in,
	output sample_s          curr_in
);
	logic [7:0]  div_r;
	logic [3:0]  phase_r;
	wire         strobe = (div_r == 8'h9F);
	wire  [23:0] volt = phase_r[3] ? -amplitude : amplitude;
	// sixteen samples a cycle; freeze holds the sign so crossings stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 8'h00;
			phase_r <= 4'h0;
		end else begin
			div_r <= strobe ? 8'h00 : div_r + 8'h01;
			if (strobe && !freeze)
				phase_r <= phase_r + 4'h1;
		end
	end
	// inverted data between strobes so a stale word is never taken for a sample
	assign volt_in = '{valid: strobe, data: strobe ? volt : ~volt};
	assign curr_in = '{valid: strobe, data: strobe ? CURR_LEVEL : ~CURR_LEVEL};
endmodule : line_sample_source

/* test/testbench.sv */
// directed bench for the line monitor: APB tasks and line scenarios
// assumes the sample source model and the bound checker are compiled
`timescale 1ns/100ps
`include "line_monitor_params.svh"
module testbench
	import line_monitor_pkg::*;
;
	localparam logic [23:0] CURR = 24'h001234;
	logic        pclk, presetn, psel, penable, pwrite, freeze, pready, pslverr, re;
	logic        meter_irq, supply_irq, line_zero_cross;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [23:0] amplitude;
	sample_s     volt_in, curr_in, curr_out;
	int          num_errors, checks, n;
	line_sample_source #(.CURR_LEVEL(CURR)) line_sample_source_i (.*);
	line_power_quality_monitor line_power_quality_monitor_i (.*);
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_in(input string what, input int lo, input int hi);
		checks++;
		if (n < lo || n > hi) begin
			num_errors++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, n);
		end
	endtask : chk_in
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 16) begin
			num_errors++;
			report_and_stop();
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] exp);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), exp, {re, rv});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	// sel 0 crossing pulse, 1 meter irq, 2 supply irq; n ends at lim if never seen
	task automatic wait_for(input int sel, input int lim, input bit must);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (n < lim && (sel == 0 ? line_zero_cross : sel == 1 ? meter_irq : supply_irq) !== 1'b1);
		if (must && n >= lim) begin
			num_errors++;
			report_and_stop();
		end
	endtask : wait_for
	initial begin
		{presetn, psel, penable, pwrite, freeze, paddr, pwdata} = '0;
		amplitude = 24'h001000;
		num_errors = 0;
		checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(`OFF_ZX_TIMEOUT, 33'h000000FFF);
		rd(`OFF_CONFIG_A, 33'h000000000);
		repeat (200) @(posedge pclk);
		rd(`OFF_CURRENT_OUT, {9'h000, CURR});
		wr(`OFF_CONFIG_A, 32'h00000030);
		repeat (800) @(posedge pclk);
		apb(1'b0, `OFF_CURRENT_OUT, 32'h0);
		chk("integrator changes current", 33'h0, {32'h0, rv[23:0] === CURR});
		wr(`OFF_CONFIG_A, 32'h00000010);
		wr(`OFF_ZX_TIMEOUT, 32'h00000123);
		rd(`OFF_ZX_TIMEOUT, 33'h000000123);
		rd(8'h3F, 33'h100000000);
		wr(`OFF_ZX_TIMEOUT, 32'h0000000A);
		$display("test registers done");
		wr(`OFF_METER_EN_HI, 32'h00000004);
		wr(`OFF_METER_ST_HI, 32'h00000006);
		wait_for(0, 2000, 1'b1);
		rd(`OFF_METER_ST_HI, 33'h000000004);
		chk("meter_irq", 33'h1, {32'h0, meter_irq});
		wr(`OFF_METER_ST_HI, 32'h00000004);
		rd(`OFF_METER_ST_HI, 33'h000000000);
		wr(`OFF_CONFIG_B, 32'h00000000);
		repeat (3) wait_for(0, 2000, 1'b1);
		rd(`OFF_PERIOD_FREQ, 33'h000000100);
		wr(`OFF_CONFIG_B, 32'h00000002);
		repeat (3) wait_for(0, 2000, 1'b1);
		rd(`OFF_PERIOD_FREQ, 33'h000006400);
		$display("test crossing and period done");
		wr(`OFF_METER_EN_HI, 32'h00000002);
		wr(`OFF_METER_ST_HI, 32'h00000006);
		wait_for(1, 3000, 1'b0);
		chk_in("timeout with line present", 3000, 3000);
		wait_for(0, 2000, 1'b1);
		freeze <= 1'b1;
		wait_for(1, 3000, 1'b1);
		chk_in("cycles to timeout", 1430, 1610);
		rd(`OFF_METER_ST_HI, 33'h000000006);
		freeze <= 1'b0;
		$display("test timeout done");
		wr(`OFF_DIP_LEVEL, 32'h00000008);
		wr(`OFF_DIP_CYCLES, 32'h00000004);
		wr(`OFF_SUPPLY_EN, 32'h00000020);
		wr(`OFF_SUPPLY_FLAGS, 32'h00000020);
		wait_for(0, 2000, 1'b1);
		amplitude <= 24'h000400;
		wait_for(2, 12000, 1'b1);
		chk_in("cycles to dip flag", 6000, 10500);
		rd(`OFF_SUPPLY_FLAGS, 33'h000000020);
		wr(`OFF_DIP_LEVEL, 32'h00000001);
		wr(`OFF_SUPPLY_FLAGS, 32'h00000020);
		repeat (2) @(posedge pclk);
		wait_for(2, 13000, 1'b0);
		chk_in("dip at zero level", 13000, 13000);
		$display("test dip done");
		wr(`OFF_CONFIG_A, 32'h00000000);
		wait_for(0, 4000, 1'b1);
		chk_in("crossing through low-pass", 1, 4000);
		$display("test low-pass done");
		report_and_stop();
	end
endmodule : testbench
